// ===== include/cfg_commit_pkg.sv
package cfg_commit_pkg;
  // serial framing
  localparam int          BITS_PER_BYTE    = 8;
  localparam int          ADDR_W           = 7;
  localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h48; // bus address, value arbitrary
  localparam logic        RW_WRITE         = 1'b0;
  // command and location bytes
  localparam logic [7:0]  CMD_START_CONV   = 8'h51;
  localparam logic [7:0]  CMD_COPY_NV      = 8'h48;
  localparam logic [7:0]  CMD_HALT_CONV    = 8'h22;
  localparam logic [7:0]  LOC_CFG_MSB      = 8'hac;
  // configuration msb layout and reset values
  localparam int          CFG_ONESHOT_BIT  = 0;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  // nonvolatile write time
  localparam int          CLK_HZ           = 50_000_000;
  localparam int          NV_WRITE_MS      = 10;
  localparam int          NV_WRITE_CYCLES  = (CLK_HZ / 1000) * NV_WRITE_MS;

  // command sequencer states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_ADDR   = 5'b00010,
    ST_CMD    = 5'b00100,
    ST_DATA   = 5'b01000,
    ST_IGNORE = 5'b10000
  } cmd_state_t;
endpackage

// ===== include/byte_link_if.sv
interface byte_link_if;
  logic       start;
  logic       stop;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       ack_en;

  modport front (
    output start,
    output stop,
    output byte_valid,
    output byte_data,
    input  ack_en
  );
  modport cmd (
    input  start,
    input  stop,
    input  byte_valid,
    input  byte_data,
    output ack_en
  );
endinterface

// ===== rtl/twowire_byte_rx.sv
module twowire_byte_rx (
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_oe_ff,
  byte_link_if.front link
);
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic [3:0] bit_cnt_ff;
  logic       in_ack_ff;
  logic [7:0] shift_ff;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // previous line levels for edge and condition detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q_ff;
  assign scl_fall = ~scl_in & scl_q_ff;
  assign start_c  = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
  assign stop_c   = scl_in & scl_q_ff & ~sda_q_ff & sda_in;

  // bit counter, shifter and ack phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_ff <= 4'h0;
      in_ack_ff  <= 1'b0;
      shift_ff   <= 8'h00;
    end else if (start_c || stop_c) begin
      bit_cnt_ff <= 4'h0;
      in_ack_ff  <= 1'b0;
    end else if (scl_rise && bit_cnt_ff < 4'(cfg_commit_pkg::BITS_PER_BYTE)) begin
      shift_ff   <= {shift_ff[6:0], sda_in};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (scl_fall && bit_cnt_ff == 4'(cfg_commit_pkg::BITS_PER_BYTE)) begin
      in_ack_ff  <= ~in_ack_ff;
      if (in_ack_ff) begin
        bit_cnt_ff <= 4'h0;
      end
    end
  end

  // pulses toward the command sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.start      <= 1'b0;
      link.stop       <= 1'b0;
      link.byte_valid <= 1'b0;
      link.byte_data  <= 8'h00;
    end else begin
      link.start      <= start_c;
      link.stop       <= stop_c;
      link.byte_valid <= scl_rise & ~start_c & ~stop_c
                         & (bit_cnt_ff == 4'(cfg_commit_pkg::BITS_PER_BYTE - 1));
      if (scl_rise) begin
        link.byte_data <= {shift_ff[6:0], sda_in};
      end
    end
  end

  // pull sda low through the ack clock when the sequencer agrees
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_ff <= 1'b0;
    end else if (start_c || stop_c) begin
      sda_oe_ff <= 1'b0;
    end else if (scl_fall && bit_cnt_ff == 4'(cfg_commit_pkg::BITS_PER_BYTE)) begin
      sda_oe_ff <= ~in_ack_ff & link.ack_en;
    end
  end
endmodule

// ===== rtl/config_commit_cmd.sv
// Function
// [R1] master addresses us for write before each command; we acknowledge the address
// [R2] master sends 51h to begin temperature conversions
// [R3] on 51h we acknowledge and start converting
// [R4] location byte ACh selects the configuration msb holding single-conversion mode
// [R5] configuration writes change only the shadow copy, never the nonvolatile cell; a write while busy still reaches config_nv when the copy ends
// [R6] master rewrites the configuration only when single-conversion mode is wanted
// [R7] written configuration with bit 0 set sets single-conversion mode
// [R8] on 48h we acknowledge and copy shadow into nonvolatile memory
// [R9] on 22h we acknowledge and stop continuous conversion
// [R10] master waits 10 ms or polls busy before halting conversions
// [R11] master uses repeated start plus write address between commands
// [R12] master ends with stop, or a repeated start to continue
// [R13] written configuration with bit 0 clear enters continuous conversion
// [R14] busy flag held from copy acceptance until the nonvolatile write ends
module config_commit_cmd #(
  parameter logic [6:0] DEV_ADDR        = cfg_commit_pkg::DEV_ADDR_DEFAULT,
  parameter int         NV_WRITE_CYCLES = cfg_commit_pkg::NV_WRITE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            conv_active,
  output logic            single_conversion_mode,
  output logic            nonvolatile_busy_flag,
  output logic      [7:0] config_shadow,
  output logic      [7:0] config_nv
);
  localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

  byte_link_if link ();

  cfg_commit_pkg::cmd_state_t state_ff;
  cfg_commit_pkg::cmd_state_t nxt_state;
  logic             nxt_ack;
  logic             addr_hit;
  logic             do_start;
  logic             do_copy;
  logic             do_halt;
  logic             do_cfg;
  logic             conv_ff;
  logic             oneshot_ff;
  logic             busy_ff;
  logic [7:0]       shadow_ff;
  logic [7:0]       nv_ff;
  logic [CNT_W-1:0] nv_cnt_ff;

  // bit level front end
  twowire_byte_rx u_rx (
    .clk       (clk),
    .resetn    (resetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_oe_ff (sda_oe),
    .link      (link.front)
  );

  assign sda_out = 1'b0; // open drain, only ever pulls low

  // decode of the byte just received
  always_comb begin
    nxt_state = state_ff;
    nxt_ack   = 1'b0;
    do_start  = 1'b0;
    do_copy   = 1'b0;
    do_halt   = 1'b0;
    do_cfg    = 1'b0;
    addr_hit  = (link.byte_data == {DEV_ADDR, cfg_commit_pkg::RW_WRITE});
    if (link.byte_valid) begin
      unique case (state_ff)
        cfg_commit_pkg::ST_ADDR: begin
          nxt_ack   = addr_hit; // R1
          nxt_state = addr_hit ? cfg_commit_pkg::ST_CMD : cfg_commit_pkg::ST_IGNORE;
        end
        cfg_commit_pkg::ST_CMD: begin
          nxt_state = cfg_commit_pkg::ST_IGNORE;
          unique case (link.byte_data)
            cfg_commit_pkg::CMD_START_CONV: begin
              do_start = 1'b1; // R3
              nxt_ack  = 1'b1;
            end
            cfg_commit_pkg::CMD_COPY_NV: begin
              do_copy = 1'b1; // R8
              nxt_ack = 1'b1;
            end
            cfg_commit_pkg::CMD_HALT_CONV: begin
              do_halt = 1'b1; // R9
              nxt_ack = 1'b1;
            end
            cfg_commit_pkg::LOC_CFG_MSB: begin
              nxt_ack   = 1'b1; // R4
              nxt_state = cfg_commit_pkg::ST_DATA;
            end
            default: nxt_ack = 1'b0;
          endcase
        end
        cfg_commit_pkg::ST_DATA: begin
          do_cfg    = 1'b1;
          nxt_ack   = 1'b1;
          nxt_state = cfg_commit_pkg::ST_IGNORE;
        end
        cfg_commit_pkg::ST_IDLE,
        cfg_commit_pkg::ST_IGNORE: nxt_state = state_ff;
      endcase
    end
  end

  // sequencer state; start and stop override everything
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= cfg_commit_pkg::ST_IDLE;
    end else if (link.stop) begin
      state_ff <= cfg_commit_pkg::ST_IDLE;
    end else if (link.start) begin
      state_ff <= cfg_commit_pkg::ST_ADDR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ack decision handed to the front end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.ack_en <= 1'b0;
    end else if (link.start || link.stop) begin
      link.ack_en <= 1'b0;
    end else if (link.byte_valid) begin
      link.ack_en <= nxt_ack;
    end
  end

  // conversion run flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_ff <= 1'b0;
    end else if (do_start) begin
      conv_ff <= 1'b1; // R3
    end else if (do_halt) begin
      conv_ff <= 1'b0; // R9
    end
  end

  // shadow configuration msb and mode bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shadow_ff  <= cfg_commit_pkg::CFG_RESET;
      oneshot_ff <= cfg_commit_pkg::CFG_RESET[cfg_commit_pkg::CFG_ONESHOT_BIT];
    end else if (do_cfg) begin
      shadow_ff  <= link.byte_data; // R5
      oneshot_ff <= link.byte_data[cfg_commit_pkg::CFG_ONESHOT_BIT]; // R7 R13
    end
  end

  // nonvolatile copy timer; a copy while busy restarts the write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff   <= 1'b0;
      nv_cnt_ff <= '0;
      nv_ff     <= cfg_commit_pkg::CFG_RESET;
    end else if (do_copy) begin
      busy_ff   <= 1'b1; // R14
      nv_cnt_ff <= CNT_W'(NV_WRITE_CYCLES);
    end else if (busy_ff) begin
      nv_cnt_ff <= nv_cnt_ff - CNT_W'(1);
      if (nv_cnt_ff == CNT_W'(1)) begin
        busy_ff <= 1'b0; // R14
        nv_ff   <= shadow_ff; // R8
      end
    end
  end

  // registered outputs
  assign conv_active            = conv_ff;
  assign single_conversion_mode = oneshot_ff;
  assign nonvolatile_busy_flag  = busy_ff;
  assign config_shadow          = shadow_ff;
  assign config_nv              = nv_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_ADDR_ACK: assert property ( // R1
    link.byte_valid && state_ff == cfg_commit_pkg::ST_ADDR && addr_hit
    |=> link.ack_en && state_ff == cfg_commit_pkg::ST_CMD)
    else $error("own write address not acknowledged");

  AST_ADDR_NACK: assert property ( // R1
    link.byte_valid && state_ff == cfg_commit_pkg::ST_ADDR && !addr_hit
    |=> !link.ack_en)
    else $error("foreign address acknowledged");

  AST_START_CONV: assert property ( // R3
    do_start |=> conv_active && link.ack_en)
    else $error("start command did not start conversion");

  AST_CFG_SELECT: assert property ( // R4
    link.byte_valid && state_ff == cfg_commit_pkg::ST_CMD
    && link.byte_data == cfg_commit_pkg::LOC_CFG_MSB && !link.start && !link.stop
    |=> state_ff == cfg_commit_pkg::ST_DATA && link.ack_en)
    else $error("configuration location not selected");

  AST_SHADOW_ONLY: assert property ( // R5
    do_cfg && !busy_ff |=> $stable(config_nv) && config_shadow == $past(link.byte_data))
    else $error("configuration write touched nonvolatile copy");

  AST_SET_ONESHOT: assert property ( // R7
    do_cfg && link.byte_data[cfg_commit_pkg::CFG_ONESHOT_BIT] |=> single_conversion_mode)
    else $error("single conversion mode not set");

  AST_CLR_ONESHOT: assert property ( // R13
    do_cfg && !link.byte_data[cfg_commit_pkg::CFG_ONESHOT_BIT] |=> !single_conversion_mode)
    else $error("single conversion mode not cleared");

  AST_COPY_BUSY: assert property ( // R8
    do_copy |=> nonvolatile_busy_flag && link.ack_en ##1 nonvolatile_busy_flag)
    else $error("copy command not accepted");

  AST_HALT_CONV: assert property ( // R9
    do_halt && !do_start |=> !conv_active && link.ack_en)
    else $error("halt command did not stop conversion");

  AST_BUSY_END: assert property ( // R14
    busy_ff && nv_cnt_ff == CNT_W'(1) && !do_copy
    |=> !nonvolatile_busy_flag && config_nv == $past(config_shadow))
    else $error("nonvolatile write did not complete cleanly");

  COV_START_CONV: cover property (do_start ##[1:1000] link.start);
  COV_CFG_ONESHOT: cover property (do_cfg && link.byte_data[0]);
  COV_COPY_DONE: cover property (busy_ff ##1 !busy_ff);
  COV_HALT: cover property (conv_ff ##1 do_halt);
endmodule

// ===== verif/twowire_master_model.sv
module twowire_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles with scl driven high and sda released, pull-up holds sda high
  initial begin
    scl          = 1'b1;
    sda_pull_low = 1'b0;
  end

  // one scl phase of four clocks, launched just after the edge
  task automatic phase();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start_cond();
    sda_pull_low = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sda_pull_low = 1'b1;
    phase();
    scl = 1'b0;
    phase();
  endtask

  // stop: sda rises while scl high
  task automatic stop_cond();
    sda_pull_low = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sda_pull_low = 1'b0;
    phase();
  endtask

  // eight bits msb first, then ninth clock with sda released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull_low = ~b[i];
      phase();
      scl = 1'b1;
      phase();
      scl = 1'b0;
    end
    sda_pull_low = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    ack = (sda === 1'b0);
    scl = 1'b0;
  endtask
endmodule

// ===== verif/tb_config_commit_cmd.sv
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_config_commit_cmd;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int         NV_CYCLES = 20;
  localparam logic [6:0] ADDR      = cfg_commit_pkg::DEV_ADDR_DEFAULT;
  localparam logic [7:0] ADDR_WR   = {ADDR, cfg_commit_pkg::RW_WRITE};

  logic       clk = 1'b0;
  logic       resetn;
  logic       scl;
  logic       m_low;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       conv_active;
  logic       mode;
  logic       busy;
  logic [7:0] shadow;
  logic [7:0] nv;
  int         mismatches = 0;
  int         compares = 0;
  int         busy_cycles = 0;

  always #10 clk = ~clk;

  // busy high time, sampled just after each edge
  always @(posedge clk) begin
    #1;
    if (busy === 1'b1) begin
      busy_cycles++;
    end
  end
  // wired-and with pull-up
  assign sda = !(m_low || sda_oe);

  twowire_master_model u_twowire_master_model (
    .clk          (clk),
    .sda          (sda),
    .scl          (scl),
    .sda_pull_low (m_low)
  );

  config_commit_cmd #(.DEV_ADDR(ADDR), .NV_WRITE_CYCLES(NV_CYCLES)) u_config_commit_cmd (
    .clk                    (clk),
    .resetn                 (resetn),
    .scl_in                 (scl),
    .sda_in                 (sda),
    .sda_out                (sda_out),
    .sda_oe                 (sda_oe),
    .conv_active            (conv_active),
    .single_conversion_mode (mode),
    .nonvolatile_busy_flag  (busy),
    .config_shadow          (shadow),
    .config_nv              (nv)
  );

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // start, write address, then one byte
  task automatic addressed(input logic [7:0] b, output logic ack);
    logic a;
    u_twowire_master_model.start_cond();
    u_twowire_master_model.send_byte(ADDR_WR, a);
    `CHK(a, 1'b1)
    u_twowire_master_model.send_byte(b, ack);
  endtask

  task automatic test_reset();
    `CHK({sda_out, sda_oe, conv_active, mode, busy, shadow, nv}, 21'h0)
    $display("test_reset done");
  endtask

  // foreign address, read bit and unknown command stay unanswered
  task automatic test_refused();
    logic a;
    u_twowire_master_model.start_cond();
    u_twowire_master_model.send_byte(ADDR_WR + 8'h02, a);
    `CHK(a, 1'b0)
    u_twowire_master_model.start_cond();
    u_twowire_master_model.send_byte(ADDR_WR | 8'h01, a);
    `CHK(a, 1'b0)
    addressed(8'h00, a);
    `CHK(a, 1'b0)
    $display("test_refused done");
  endtask

  task automatic test_start_conv();
    logic a;
    addressed(cfg_commit_pkg::CMD_START_CONV, a);
    `CHK(a, 1'b1)
    `CHK(conv_active, 1'b1)
    $display("test_start_conv done");
  endtask

  // mode set, cleared, set again; only the shadow moves
  task automatic test_cfg_write();
    logic [7:0] vals[3] = '{8'h01, 8'hfe, 8'h01};
    logic       a;
    foreach (vals[i]) begin
      addressed(cfg_commit_pkg::LOC_CFG_MSB, a);
      `CHK(a, 1'b1)
      u_twowire_master_model.send_byte(vals[i], a);
      `CHK(a, 1'b1)
      `CHK(mode, vals[i][0])
      `CHK(shadow, vals[i])
      `CHK(nv, 8'h00)
    end
    u_twowire_master_model.send_byte(8'h55, a);
    `CHK(a, 1'b0)
    $display("test_cfg_write done");
  endtask

  // copy, poll busy, then halt and stop
  task automatic test_copy_halt();
    logic a;
    int   n;
    addressed(cfg_commit_pkg::CMD_COPY_NV, a);
    `CHK(a, 1'b1)
    `CHK(busy, 1'b1)
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n < NV_CYCLES, 1'b1)
    `CHK(busy_cycles, NV_CYCLES)
    `CHK(busy, 1'b0)
    `CHK(nv, 8'h01)
    addressed(cfg_commit_pkg::CMD_HALT_CONV, a);
    `CHK(a, 1'b1)
    `CHK(conv_active, 1'b0)
    `CHK({mode, nv}, 9'h101)
    u_twowire_master_model.stop_cond();
    $display("test_copy_halt done");
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    test_reset();
    test_refused();
    test_start_conv();
    test_cfg_write();
    test_copy_halt();
    report_and_stop();
  end
endmodule
